/* design/amcs_top.sv */
/*
 audio master clock select: multiplies the recovered audio bit clock by 1, 2 or 4.
 assumes config bits come from a register block as plain levels, synchronous to clk.
*/
// Operation
// R1 - master clock is x1, x2 or x4
// R2 - pll disabled keeps master clock off
// R3 - default ratio is twice bit clock
// R4 - ratio code from three-bit config field
// R5 - software sets override before ratio code
// R6 - code is base plus multiplier step
// R7 - lock to bit clock; override gates code
// R8 - software disables pll below 1 mhz
`timescale 1ns/100ps
`default_nettype none
`include "amcs_defines.svh"

module amcs_top (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire amcs_pkg::amcs_cfg_t cfg,
    input  wire logic               bit_clk,
    output logic                    mclk,
    output logic                    mclk_active,
    output var  amcs_pkg::amcs_mult_t mult_sel
);
    import amcs_pkg::*;

    logic        rst_s1_ff;
    logic        rst_n_ff;
    logic [2:0]  ratio_ff;
    amcs_state_t state_ff;
    amcs_state_t nxt_state;
    logic [3:0]  lock_cnt_ff;
    logic        bclk_d_ff;
    logic        run;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // R3 default x2 code
    // R4 field taken when override set
    // R5 R7 override gates code
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ratio_ff <= `AMCS_RATIO_RESET;
        end else if (cfg.override_en) begin
            ratio_ff <= cfg.master_clock_ratio_select;
        end else begin
            ratio_ff <= `AMCS_RATIO_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            bclk_d_ff <= 1'b0;
        end else begin
            bclk_d_ff <= bit_clk;
        end
    end

    // R7 relock after enable
    always_comb begin
        case (state_ff)
            AMCS_ST_OFF:  nxt_state = cfg.pll_disable ? AMCS_ST_OFF : AMCS_ST_LOCK;
            AMCS_ST_LOCK: nxt_state = cfg.pll_disable ? AMCS_ST_OFF :
                          (lock_cnt_ff >= 4'(`AMCS_LOCK_CYCLES)) ? AMCS_ST_RUN : AMCS_ST_LOCK;
            AMCS_ST_RUN:  nxt_state = cfg.pll_disable ? AMCS_ST_OFF : AMCS_ST_RUN;
            default:      nxt_state = AMCS_ST_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= AMCS_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // counts bit clock rising edges while locking
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lock_cnt_ff <= 4'h0;
        end else if (state_ff != AMCS_ST_LOCK) begin
            lock_cnt_ff <= 4'h0;
        end else if (bit_clk && !bclk_d_ff && lock_cnt_ff != 4'hf) begin
            lock_cnt_ff <= lock_cnt_ff + 4'h1;
        end
    end

    // R2 disabled pll gates output
    assign run = (state_ff == AMCS_ST_RUN) && !cfg.pll_disable;

    // R1 R6 multiplier from code
    amcs_mult u_mult (
        .clk        (clk),
        .rst_n      (rst_n_ff),
        .run        (run),
        .ratio_code (ratio_ff),
        .bit_clk    (bit_clk),
        .mult       (mult_sel),
        .mclk       (mclk)
    );

    assign mclk_active = run;
endmodule

`default_nettype wire

/* design/amcs_defines.svh */
/*
 audio master clock select constants: register field positions, reset values, timing.
 assumes inclusion by bare name from design files.
*/
`ifndef AMCS_DEFINES_SVH
`define AMCS_DEFINES_SVH

`define AMCS_CFG_REG_ADDR      8'h3a
`define AMCS_PLL_REG_ADDR      8'h2b
`define AMCS_OVR_BIT           7
`define AMCS_RATIO_MSB         6
`define AMCS_RATIO_LSB         4
`define AMCS_PLL_DIS_BIT       7
`define AMCS_RATIO_RESET       3'h1
`define AMCS_BASE_LE_1536      3'h0
`define AMCS_BASE_LE_3072      3'h1
`define AMCS_BASE_LE_6144      3'h2
`define AMCS_BASE_LE_12288     3'h3
`define AMCS_CODE_12288_X4     3'h6
`define AMCS_CLK_PERIOD_NS     100
`define AMCS_LOCK_TIME_NS      800
`define AMCS_LOCK_CYCLES       ((`AMCS_LOCK_TIME_NS + `AMCS_CLK_PERIOD_NS - 1) / `AMCS_CLK_PERIOD_NS)

`endif

/* design/amcs_pkg.sv */
/*
 types for the audio master clock select block.
 assumes amcs_defines.svh is on the include path.
*/
package amcs_pkg;

    typedef enum logic [1:0] {
        AMCS_MULT_X1 = 2'd0,
        AMCS_MULT_X2 = 2'd1,
        AMCS_MULT_X4 = 2'd2
    } amcs_mult_t;

    typedef struct packed {
        logic       override_en;
        logic [2:0] master_clock_ratio_select;
        logic       pll_disable;
    } amcs_cfg_t;

    typedef enum logic [2:0] {
        AMCS_ST_OFF  = 3'b001,
        AMCS_ST_LOCK = 3'b010,
        AMCS_ST_RUN  = 3'b100
    } amcs_state_t;

endpackage

/* design/amcs_mult.sv */
/*
 ratio-code decoder and edge multiplier producing the master clock.
 assumes bit clock input already synchronous to clk and no faster than clk/8.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amcs_defines.svh"

module amcs_mult (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               run,
    input  wire logic [2:0]         ratio_code,
    input  wire logic               bit_clk,
    output var  amcs_pkg::amcs_mult_t mult,
    output logic                    mclk
);
    import amcs_pkg::*;

    logic       bclk_d_ff;
    logic [7:0] per_cnt_ff;
    logic [7:0] per_len_ff;
    logic [7:0] acc_ff;
    logic       mclk_ff;
    logic [7:0] step;
    logic [8:0] acc_sum;
    logic [2:0] base;

    // code minus table base gives multiplier; code 6 is forced to x4
    always_comb begin
        base = (ratio_code >= `AMCS_BASE_LE_12288) ? `AMCS_BASE_LE_12288 : 3'h0;
        if (ratio_code == `AMCS_CODE_12288_X4) begin
            mult = AMCS_MULT_X4;
        end else begin
            case (ratio_code - base)
                3'h0:    mult = AMCS_MULT_X1;
                3'h1:    mult = AMCS_MULT_X2;
                3'h2:    mult = AMCS_MULT_X4;
                default: mult = AMCS_MULT_X2;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_d_ff  <= 1'b0;
            per_cnt_ff <= 8'h00;
            per_len_ff <= 8'h00;
        end else begin
            bclk_d_ff <= bit_clk;
            if (bit_clk && !bclk_d_ff) begin
                per_len_ff <= per_cnt_ff;
                per_cnt_ff <= 8'h01;
            end else if (per_cnt_ff != 8'hff) begin
                per_cnt_ff <= per_cnt_ff + 8'h01;
            end
        end
    end

    // two toggles per output period, spread evenly over the bit period
    assign step    = 8'h02 << mult;
    assign acc_sum = {1'b0, acc_ff} + {1'b0, step};

    // resync high on each bit clock rise; too fast or unmeasured clock stays off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff  <= 8'h00;
            mclk_ff <= 1'b0;
        end else if (!run || per_len_ff < 8'h08) begin
            acc_ff  <= 8'h00;
            mclk_ff <= 1'b0;
        end else if (bit_clk && !bclk_d_ff) begin
            acc_ff  <= 8'h00;
            mclk_ff <= 1'b1;
        end else if (acc_sum >= {1'b0, per_len_ff}) begin
            acc_ff  <= 8'(acc_sum - {1'b0, per_len_ff});
            mclk_ff <= ~mclk_ff;
        end else begin
            acc_ff  <= acc_sum[7:0];
        end
    end

    assign mclk = mclk_ff;
endmodule

`default_nettype wire

/* tb/amcs_properties.sv */
/* amcs checker: port assertions of amcs_top.
 bound from the bench top file. */
`timescale 1ns/100ps
`default_nettype none
module amcs_chk (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire amcs_pkg::amcs_cfg_t  cfg,
    input wire logic                 bit_clk,
    input wire logic                 mclk,
    input wire logic                 mclk_active,
    input wire amcs_pkg::amcs_mult_t mult_sel
);
    import amcs_pkg::*;
    logic [1:0] up_ff;
    // skip the reset synchroniser cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            up_ff <= 2'h0;
        else if (up_ff != 2'h3)
            up_ff <= up_ff + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_off; cfg.pll_disable |=> !mclk_active && !mclk; endproperty
    a_off: assert property (p_off) else $error("mclk not off");
    property p_gate; !mclk_active |=> !mclk; endproperty
    a_gate: assert property (p_gate) else $error("mclk while idle");
    property p_dflt; up_ff == 2'h3 && !cfg.override_en |=> mult_sel == AMCS_MULT_X2; endproperty
    a_dflt: assert property (p_dflt) else $error("default not x2");
    property p_x4;
        up_ff == 2'h3 && cfg.override_en && cfg.master_clock_ratio_select == 3'h6
            |=> mult_sel == AMCS_MULT_X4;
    endproperty
    a_x4: assert property (p_x4) else $error("code 110 not x4");
    property p_x1;
        up_ff == 2'h3 && cfg.override_en && cfg.master_clock_ratio_select inside {3'h0, 3'h3}
            |=> mult_sel == AMCS_MULT_X1;
    endproperty
    a_x1: assert property (p_x1) else $error("field not x1");
    property p_lock; up_ff == 2'h3 && $fell(cfg.pll_disable) |-> !mclk_active [*8]; endproperty
    a_lock: assert property (p_lock) else $error("no lock wait");
    property p_run; up_ff == 2'h3 && $fell(cfg.pll_disable) |-> ##[1:300] mclk_active; endproperty
    a_run: assert property (p_run) else $error("never runs");
endmodule
`default_nettype wire

/* tb/amcs_dac_model.sv */
/* far-side codec model: counts master clock rises.
 assumes mclk comes from a clk flop. */
`timescale 1ns/100ps
`default_nettype none
module amcs_dac_model (
    input  wire logic       clk,
    input  wire logic       mclk,
    input  wire logic       clear,
    output logic [7:0]      rises
);
    logic last_ff;
    always_ff @(posedge clk) begin
        last_ff <= mclk;
        if (clear)
            rises <= 8'h00;
        else if (mclk && !last_ff)
            rises <= rises + 8'h01;
    end
endmodule
`default_nettype wire

/* tb/tb_audio_master_clock_select.sv */
/* bench for amcs_top with codec model.
 assumes the design package and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_audio_master_clock_select;
    import amcs_pkg::*;
    logic       clk, reset_n, bit_clk, mclk, mclk_active, clr;
    logic [7:0] rises;
    logic [3:0] bc;
    amcs_cfg_t  cfg;
    amcs_mult_t mult_sel;
    amcs_mult_t em [7] = '{AMCS_MULT_X1, AMCS_MULT_X2, AMCS_MULT_X4, AMCS_MULT_X1,
                           AMCS_MULT_X2, AMCS_MULT_X4, AMCS_MULT_X4};
    int         err_total, checks_done, cyc;
    amcs_top i_amcs_top (.clk(clk), .reset_n(reset_n), .cfg(cfg), .bit_clk(bit_clk),
        .mclk(mclk), .mclk_active(mclk_active), .mult_sel(mult_sel));
    amcs_dac_model i_amcs_dac_model (.clk(clk), .mclk(mclk), .clear(clr), .rises(rises));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // bit clock kept at 1 mhz, never below; cycle limit
    always @(posedge clk) begin
        bc <= (bc == 4'h9) ? 4'h0 : bc + 4'h1;
        bit_clk <= (bc < 4'h5);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            wrap_up;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic measure(input int m);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (200) @(posedge clk);
        #1 check(8'(rises >= 18 * m && rises <= 22 * m), 8'h01);
    endtask
    task automatic t_off;
        @(posedge clk) cfg.pll_disable <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(8'(mclk_active), 8'h00);
        measure(0);
        check(8'(mult_sel), 8'(AMCS_MULT_X2));
        $display("off test done");
    endtask
    task automatic t_default;
        @(posedge clk) cfg <= '{1'b0, 3'h6, 1'b0};
        for (int i = 0; i < 300 && mclk_active !== 1'b1; i++) @(posedge clk);
        #1 check(8'(mclk_active), 8'h01);
        check(8'(mult_sel), 8'(AMCS_MULT_X2));
        measure(2);
        $display("default test done");
    endtask
    task automatic t_codes;
        for (int c = 0; c < 7; c++) begin
            @(posedge clk) cfg.override_en <= 1'b1;
            @(posedge clk) cfg.master_clock_ratio_select <= 3'(c);
            repeat (2) @(posedge clk);
            #1 check(8'(mult_sel), 8'(em[c]));
            measure(1 << em[c]);
        end
        @(posedge clk) cfg.override_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(8'(mult_sel), 8'(AMCS_MULT_X2));
        $display("code test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        cfg = '{1'b0, 3'h0, 1'b1};
        clr = 1'b0;
        bit_clk = 1'b0;
        bc = 4'h0;
        cyc = 0;
        err_total = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_off;
        t_default;
        t_codes;
        t_off;
        wrap_up;
    end
endmodule
bind amcs_top amcs_chk i_amcs_chk (.clk(clk), .reset_n(reset_n), .cfg(cfg), .bit_clk(bit_clk),
    .mclk(mclk), .mclk_active(mclk_active), .mult_sel(mult_sel));
`default_nettype wire
